// ===== src/fso_pkg.sv
// Function
// - ready is high only when a new operation may be started.
// - fault follows any abnormal system condition.
// - cycle_done rises when a cycle ends, also when cut short by a fault.
// - one judged cycle gives either pass or fail, never both.
// - a batch verdict gives batch_pass or batch_fail.
// - seat rises once the seating torque is reached.
// - reverse_active follows the tool reverse switch unless the latest cycle was externally started.
// - in externally started cycles reverse_active follows the external reverse input.
// - with sequencing on, sequence_done rises when all steps are finished.
// - lock_echo follows the lock input.
// - serial_err rises on a fault while reporting on the primary serial port.
// - with sequencing on, step_done rises after each step.
// - sequence_active is high while a job runs.
// - sequence_aborted rises when a running job is aborted.
// - sequence_pass rises when a running job ends, unless counting every attempt and a fail occurred.
// - pass-only counting: sequence_fail rises on the reject input.
// - count-every-attempt: sequence_fail at job end if any fail occurred.
// - tool_inhibited needs tool locked, lock input high and count complete.
// - strobe high, capture identifier, raise ack; strobe low, drop ack.
// - channel echo is binary on seven bits weighted 1 to 64.
// - with sequencing on, the echo reports the operating channel.
package fso_pkg;

    // bus
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_VID = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_CLEAR = 4'hC;

    // control register fields
    localparam int CTRL_SEQ_EN = 0;
    localparam int CTRL_ALL_COUNT = 1;
    localparam int CTRL_CHAN_LSB = 8;
    localparam int CTRL_CHAN_MSB = 14;

    // clear register fields, write one to clear
    localparam int CLR_CYCLE = 0;
    localparam int CLR_BATCH = 1;
    localparam int CLR_SEQ = 2;
    localparam int CLR_SERIAL = 3;

    localparam int CHAN_W = 7;
    localparam int VID_W = 32;
    localparam int STAT_W = 27;
    localparam logic [CHAN_W-1:0] CHAN_RST = 7'h01;

    // events and levels from the tool engine
    typedef struct packed {
        logic cycle_begin;
        logic ext_start;
        logic cycle_end;
        logic judged_ok;
        logic judged_ng;
        logic seat_reached;
        logic batch_ok;
        logic batch_ng;
        logic fault;
        logic serial_err;
        logic step_end;
        logic job_start;
        logic job_end;
        logic job_abort;
        logic tool_locked;
        logic count_complete;
        logic tool_rev_sw;
        logic [CHAN_W-1:0] op_channel;
    } fso_event_t;

    // output allocation bits
    typedef struct packed {
        logic ready;
        logic busy;
        logic fault;
        logic cycle_done;
        logic pass;
        logic fail;
        logic batch_pass;
        logic batch_fail;
        logic seat;
        logic reverse_active;
        logic sequence_done;
        logic lock_echo;
        logic serial_err;
        logic step_done;
        logic sequence_active;
        logic sequence_aborted;
        logic sequence_pass;
        logic sequence_fail;
        logic tool_inhibited;
        logic vehicle_id_ack;
        logic [CHAN_W-1:0] channel_echo;
    } fso_status_t;

    typedef enum logic [1:0] {
        VID_IDLE = 2'b00,
        VID_CAPTURE = 2'b01,
        VID_ACK = 2'b10
    } fso_vid_state_t;

endpackage : fso_pkg

// ===== src/fso_status_outputs.sv
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module fso_status_outputs (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [fso_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [fso_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [fso_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // tool engine
    input wire fso_pkg::fso_event_t engine_ev,
    input wire logic [fso_pkg::VID_W-1:0] vehicle_id,
    // line controller inputs
    input wire logic ext_reverse,
    input wire logic lock,
    input wire logic reject,
    input wire logic vehicle_id_strobe,
    // output allocation bits
    output fso_pkg::fso_status_t status_out
);

    logic ack_q;
    logic seq_en_q;
    logic all_count_q;
    logic [fso_pkg::CHAN_W-1:0] sel_chan_q;
    logic [fso_pkg::VID_W-1:0] vid_q;
    logic [fso_pkg::DATA_W-1:0] rdata_q;
    logic ready_q, busy_q, fault_q, done_q, pass_q, fail_q, bpass_q, bfail_q, seat_q;
    logic ext_mode_q, rev_q, seq_done_q, lock_q, ser_q, step_q, act_q, abort_q;
    logic spass_q, sfail_q, ng_seen_q, inhib_q;
    logic [fso_pkg::CHAN_W-1:0] chan_q;
    fso_pkg::fso_vid_state_t vid_st_q;
    logic wr_hit, clr_cycle, clr_batch, clr_seq, clr_ser;
    fso_pkg::fso_status_t stat;

    // bus: one wait state, writes act when waitrequest is low
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_hit = avs_write & ack_q;
    assign clr_cycle = wr_hit && avs_address == fso_pkg::OFS_CLEAR
        && avs_byteenable[0] && avs_writedata[fso_pkg::CLR_CYCLE];
    assign clr_batch = wr_hit && avs_address == fso_pkg::OFS_CLEAR
        && avs_byteenable[0] && avs_writedata[fso_pkg::CLR_BATCH];
    assign clr_seq = wr_hit && avs_address == fso_pkg::OFS_CLEAR
        && avs_byteenable[0] && avs_writedata[fso_pkg::CLR_SEQ];
    assign clr_ser = wr_hit && avs_address == fso_pkg::OFS_CLEAR
        && avs_byteenable[0] && avs_writedata[fso_pkg::CLR_SERIAL];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    // read data captured in the request cycle, unmapped reads give zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (avs_read && !ack_q) begin
            unique case (avs_address)
                fso_pkg::OFS_CTRL: begin
                    rdata_q <= '0;
                    rdata_q[fso_pkg::CTRL_SEQ_EN] <= seq_en_q;
                    rdata_q[fso_pkg::CTRL_ALL_COUNT] <= all_count_q;
                    rdata_q[fso_pkg::CTRL_CHAN_MSB:fso_pkg::CTRL_CHAN_LSB] <= sel_chan_q;
                end
                fso_pkg::OFS_STATUS: begin
                    rdata_q <= {{(fso_pkg::DATA_W-fso_pkg::STAT_W){1'b0}}, stat};
                end
                fso_pkg::OFS_VID: begin
                    rdata_q <= vid_q;
                end
                default: begin
                    rdata_q <= '0;
                end
            endcase
        end
    end
    assign avs_readdata = rdata_q;

    // control register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            seq_en_q <= 1'b0;
            all_count_q <= 1'b0;
            sel_chan_q <= fso_pkg::CHAN_RST;
        end else if (wr_hit && avs_address == fso_pkg::OFS_CTRL) begin
            if (avs_byteenable[0]) begin
                seq_en_q <= avs_writedata[fso_pkg::CTRL_SEQ_EN];
                all_count_q <= avs_writedata[fso_pkg::CTRL_ALL_COUNT];
            end
            if (avs_byteenable[1]) begin
                sel_chan_q <= avs_writedata[fso_pkg::CTRL_CHAN_MSB:fso_pkg::CTRL_CHAN_LSB];
            end
        end
    end

    // ready, busy and fault
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ready_q <= 1'b0;
            busy_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            fault_q <= engine_ev.fault;
            ready_q <= ~engine_ev.fault & ~busy_q & ~engine_ev.cycle_begin & ~inhib_q;
            if (engine_ev.fault || engine_ev.cycle_end) begin
                busy_q <= 1'b0;
            end else if (engine_ev.cycle_begin) begin
                busy_q <= 1'b1;
            end
        end
    end

    // cycle results, held until the next cycle or a clear; set wins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            done_q <= 1'b0;
            pass_q <= 1'b0;
            fail_q <= 1'b0;
            seat_q <= 1'b0;
        end else begin
            if (busy_q && (engine_ev.cycle_end || engine_ev.fault)) begin
                done_q <= 1'b1;
            end else if (engine_ev.cycle_begin || clr_cycle) begin
                done_q <= 1'b0;
            end
            if (engine_ev.judged_ng) begin
                pass_q <= 1'b0;
                fail_q <= 1'b1;
            end else if (engine_ev.judged_ok) begin
                pass_q <= 1'b1;
                fail_q <= 1'b0;
            end else if (engine_ev.cycle_begin || clr_cycle) begin
                pass_q <= 1'b0;
                fail_q <= 1'b0;
            end
            if (engine_ev.seat_reached) begin
                seat_q <= 1'b1;
            end else if (engine_ev.cycle_begin || clr_cycle) begin
                seat_q <= 1'b0;
            end
        end
    end

    // batch verdict
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bpass_q <= 1'b0;
            bfail_q <= 1'b0;
        end else if (engine_ev.batch_ng) begin
            bpass_q <= 1'b0;
            bfail_q <= 1'b1;
        end else if (engine_ev.batch_ok) begin
            bpass_q <= 1'b1;
            bfail_q <= 1'b0;
        end else if (clr_batch) begin
            bpass_q <= 1'b0;
            bfail_q <= 1'b0;
        end
    end

    // reverse echo source follows how the cycle was started
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ext_mode_q <= 1'b0;
            rev_q <= 1'b0;
        end else begin
            if (engine_ev.cycle_begin) begin
                ext_mode_q <= engine_ev.ext_start;
            end
            rev_q <= ext_mode_q ? ext_reverse : engine_ev.tool_rev_sw;
        end
    end

    // lock echo, inhibit and serial report error
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lock_q <= 1'b0;
            inhib_q <= 1'b0;
            ser_q <= 1'b0;
        end else begin
            lock_q <= lock;
            inhib_q <= engine_ev.tool_locked & lock & engine_ev.count_complete;
            if (engine_ev.serial_err) begin
                ser_q <= 1'b1;
            end else if (clr_ser) begin
                ser_q <= 1'b0;
            end
        end
    end

    // job sequencing
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            act_q <= 1'b0;
            step_q <= 1'b0;
            seq_done_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            if (engine_ev.job_start) begin
                act_q <= 1'b1;
            end else if (engine_ev.job_end || engine_ev.job_abort) begin
                act_q <= 1'b0;
            end
            if (seq_en_q && engine_ev.step_end) begin
                step_q <= 1'b1;
            end else if (engine_ev.cycle_begin || engine_ev.job_start || clr_seq) begin
                step_q <= 1'b0;
            end
            if (seq_en_q && act_q && engine_ev.job_end) begin
                seq_done_q <= 1'b1;
            end else if (engine_ev.job_start || clr_seq) begin
                seq_done_q <= 1'b0;
            end
            if (act_q && engine_ev.job_abort) begin
                abort_q <= 1'b1;
            end else if (engine_ev.job_start || clr_seq) begin
                abort_q <= 1'b0;
            end
        end
    end

    // job verdicts
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ng_seen_q <= 1'b0;
            spass_q <= 1'b0;
            sfail_q <= 1'b0;
        end else begin
            if (engine_ev.job_start) begin
                ng_seen_q <= 1'b0;
            end else if (act_q && engine_ev.judged_ng) begin
                ng_seen_q <= 1'b1;
            end
            if (act_q && engine_ev.job_end && !(all_count_q && ng_seen_q)) begin
                spass_q <= 1'b1;
            end else if (engine_ev.job_start || clr_seq) begin
                spass_q <= 1'b0;
            end
            if (!all_count_q && reject) begin
                sfail_q <= 1'b1;
            end else if (all_count_q && act_q && engine_ev.job_end && ng_seen_q) begin
                sfail_q <= 1'b1;
            end else if (engine_ev.job_start || clr_seq) begin
                sfail_q <= 1'b0;
            end
        end
    end

    // vehicle identifier handshake
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            vid_st_q <= fso_pkg::VID_IDLE;
            vid_q <= '0;
        end else begin
            unique case (vid_st_q)
                fso_pkg::VID_IDLE: begin
                    if (vehicle_id_strobe) begin
                        vid_st_q <= fso_pkg::VID_CAPTURE;
                    end
                end
                fso_pkg::VID_CAPTURE: begin
                    vid_q <= vehicle_id;
                    vid_st_q <= fso_pkg::VID_ACK;
                end
                fso_pkg::VID_ACK: begin
                    if (!vehicle_id_strobe) begin
                        vid_st_q <= fso_pkg::VID_IDLE;
                    end
                end
                default: begin
                    vid_st_q <= fso_pkg::VID_IDLE;
                end
            endcase
        end
    end

    // channel echo
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            chan_q <= fso_pkg::CHAN_RST;
        end else begin
            chan_q <= seq_en_q ? engine_ev.op_channel : sel_chan_q;
        end
    end

    always_comb begin
        stat.ready = ready_q;
        stat.busy = busy_q;
        stat.fault = fault_q;
        stat.cycle_done = done_q;
        stat.pass = pass_q;
        stat.fail = fail_q;
        stat.batch_pass = bpass_q;
        stat.batch_fail = bfail_q;
        stat.seat = seat_q;
        stat.reverse_active = rev_q;
        stat.sequence_done = seq_done_q;
        stat.lock_echo = lock_q;
        stat.serial_err = ser_q;
        stat.step_done = step_q;
        stat.sequence_active = act_q;
        stat.sequence_aborted = abort_q;
        stat.sequence_pass = spass_q;
        stat.sequence_fail = sfail_q;
        stat.tool_inhibited = inhib_q;
        stat.vehicle_id_ack = (vid_st_q == fso_pkg::VID_ACK);
        stat.channel_echo = chan_q;
    end
    assign status_out = stat;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_ready_idle;
        ready_q |-> !busy_q && !fault_q;
    endproperty
    a_ready_idle: assert property (p_ready_idle) else $error("ready while busy or faulted");

    property p_busy_start;
        engine_ev.cycle_begin && !engine_ev.fault |=> busy_q && !ready_q;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy missing at cycle start");

    property p_done_end;
        busy_q && (engine_ev.cycle_end || engine_ev.fault) |=> done_q && !busy_q;
    endproperty
    a_done_end: assert property (p_done_end) else $error("cycle done missing");

    property p_judge_excl;
        !(pass_q && fail_q);
    endproperty
    a_judge_excl: assert property (p_judge_excl) else $error("pass and fail together");

    property p_lock_echo;
        lock |=> lock_q ##1 (lock_q == $past(lock));
    endproperty
    a_lock_echo: assert property (p_lock_echo) else $error("lock echo wrong");

    property p_rev_ext;
        ext_mode_q && !engine_ev.cycle_begin |=> rev_q == $past(ext_reverse);
    endproperty
    a_rev_ext: assert property (p_rev_ext) else $error("reverse not from external input");

    property p_vid_ack_rise;
        $rose(vehicle_id_strobe) && vid_st_q == fso_pkg::VID_IDLE |=> ##1 stat.vehicle_id_ack;
    endproperty
    a_vid_ack_rise: assert property (p_vid_ack_rise) else $error("ack not raised");

    property p_vid_ack_drop;
        stat.vehicle_id_ack && !vehicle_id_strobe |=> !stat.vehicle_id_ack;
    endproperty
    a_vid_ack_drop: assert property (p_vid_ack_drop) else $error("ack not dropped");

    property p_inhibit;
        inhib_q |-> $past(lock) && $past(engine_ev.tool_locked);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit without lock");

    property p_reject;
        !all_count_q && reject |=> sfail_q;
    endproperty
    a_reject: assert property (p_reject) else $error("reject not reported");

    property p_chan_op;
        seq_en_q && $stable(seq_en_q) |=> chan_q == $past(engine_ev.op_channel);
    endproperty
    a_chan_op: assert property (p_chan_op) else $error("echo not operating channel");

    property p_bus_answer;
        (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

endmodule : fso_status_outputs

// ===== verif/fso_line_ctrl.sv
`timescale 1ns/10ps
module fso_line_ctrl (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // from the device
    input wire logic ready,
    input wire logic vehicle_id_ack,
    // bench commands
    input wire logic start_go,
    input wire logic vid_go,
    // to the device, and vid_done back to the bench
    output logic start_pls,
    output logic vehicle_id_strobe,
    output logic vid_done
);
    logic start_pend_q;
    logic [1:0] vid_st_q;

    // start only once ready is seen, strobe held until ack, then released
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            start_pend_q <= 1'b0;
            start_pls <= 1'b0;
            vehicle_id_strobe <= 1'b0;
            vid_done <= 1'b0;
            vid_st_q <= 2'h0;
        end else begin
            start_pls <= 1'b0;
            vid_done <= 1'b0;
            if (start_go) begin
                start_pend_q <= 1'b1;
            end
            if (start_pend_q && ready && !start_pls) begin
                start_pls <= 1'b1;
                start_pend_q <= 1'b0;
            end
            case (vid_st_q)
                2'h0: if (vid_go) begin
                    vehicle_id_strobe <= 1'b1;
                    vid_st_q <= 2'h1;
                end
                2'h1: if (vehicle_id_ack) begin
                    vehicle_id_strobe <= 1'b0;
                    vid_st_q <= 2'h2;
                end
                2'h2: if (!vehicle_id_ack) begin
                    vid_done <= 1'b1;
                    vid_st_q <= 2'h0;
                end
                default: vid_st_q <= 2'h0;
            endcase
        end
    end
endmodule : fso_line_ctrl

// ===== verif/tb_fso_status_outputs.sv
`timescale 1ns/10ps
module tb_fso_status_outputs;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [fso_pkg::ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [fso_pkg::DATA_W-1:0] avs_writedata = '0;
    logic [fso_pkg::DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    fso_pkg::fso_event_t ev = '0;
    fso_pkg::fso_event_t ev_in;
    fso_pkg::fso_event_t p;
    logic [fso_pkg::VID_W-1:0] vehicle_id = 32'h0000_0000;
    logic ext_reverse = 1'b0;
    logic lock = 1'b0;
    logic reject = 1'b0;
    logic start_go = 1'b0;
    logic vid_go = 1'b0;
    logic start_pls;
    logic vehicle_id_strobe;
    logic vid_done;
    fso_pkg::fso_status_t st;
    logic [31:0] rd;
    int mismatches = 0;
    int compares = 0;

    always #5 clk_sys = ~clk_sys;

    // partner start pulse enters as an externally started cycle
    always_comb begin
        ev_in = ev;
        ev_in.cycle_begin = ev.cycle_begin | start_pls;
        ev_in.ext_start = ev.ext_start | start_pls;
    end

    fso_status_outputs dut (
        .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .engine_ev(ev_in),
        .vehicle_id(vehicle_id), .ext_reverse(ext_reverse), .lock(lock), .reject(reject),
        .vehicle_id_strobe(vehicle_id_strobe), .status_out(st)
    );

    fso_line_ctrl partner (
        .clk_sys(clk_sys), .rst(rst), .ready(st.ready), .vehicle_id_ack(st.vehicle_id_ack),
        .start_go(start_go), .vid_go(vid_go), .start_pls(start_pls),
        .vehicle_id_strobe(vehicle_id_strobe), .vid_done(vid_done)
    );

    task summarize;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    task chk_bit(input string n, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit

    task chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word

    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 40) mismatches++;
        #1;
    endtask : bus

    task pulse(input fso_pkg::fso_event_t m);
        @(posedge clk_sys);
        ev <= fso_pkg::fso_event_t'(ev | m);
        @(posedge clk_sys);
        ev <= fso_pkg::fso_event_t'(ev & ~m);
        #1;
    endtask : pulse

    task t_reset;
        tick(3);
        chk_bit("ready", 1'b1, st.ready);
        chk_word("echo", 32'h1, {25'h0, st.channel_echo});
        bus(1'b0, fso_pkg::OFS_STATUS, 32'h0);
        chk_word("status", 32'h0400_0001, rd);
        bus(1'b1, 4'h6, 32'hFFFF_FFFF);
        bus(1'b0, 4'h2, 32'h0);
        chk_word("unmapped", 32'h0, rd);
        bus(1'b0, fso_pkg::OFS_CTRL, 32'h0);
        chk_word("ctrl", 32'h0000_0100, rd);
        $display("test reset done");
    endtask : t_reset

    task t_cycle;
        int n;
        n = 0;
        @(posedge clk_sys);
        ext_reverse <= 1'b1;
        start_go <= 1'b1;
        @(posedge clk_sys);
        start_go <= 1'b0;
        do begin
            tick(1);
            n++;
        end while (st.busy !== 1'b1 && n < 20);
        chk_bit("busy", 1'b1, st.busy);
        chk_bit("ready", 1'b0, st.ready);
        p = '0;
        p.seat_reached = 1'b1;
        pulse(p);
        chk_bit("seat", 1'b1, st.seat);
        chk_bit("reverse", 1'b1, st.reverse_active);
        p = '0;
        p.cycle_end = 1'b1;
        p.judged_ok = 1'b1;
        pulse(p);
        chk_bit("busy", 1'b0, st.busy);
        chk_bit("done", 1'b1, st.cycle_done);
        chk_bit("pass", 1'b1, st.pass);
        chk_bit("fail", 1'b0, st.fail);
        tick(1);
        chk_bit("ready", 1'b1, st.ready);
        @(posedge clk_sys);
        ev.tool_rev_sw <= 1'b1;
        ext_reverse <= 1'b0;
        p = '0;
        p.cycle_begin = 1'b1;
        pulse(p);
        chk_bit("done", 1'b0, st.cycle_done);
        @(posedge clk_sys);
        ev.fault <= 1'b1;
        tick(1);
        chk_bit("fault", 1'b1, st.fault);
        chk_bit("reverse", 1'b1, st.reverse_active);
        p = '0;
        p.cycle_end = 1'b1;
        p.judged_ng = 1'b1;
        pulse(p);
        chk_bit("done", 1'b1, st.cycle_done);
        chk_bit("fail", 1'b1, st.fail);
        chk_bit("pass", 1'b0, st.pass);
        chk_bit("ready", 1'b0, st.ready);
        @(posedge clk_sys);
        ev.fault <= 1'b0;
        ev.tool_rev_sw <= 1'b0;
        tick(2);
        chk_bit("fault", 1'b0, st.fault);
        $display("test cycle done");
    endtask : t_cycle

    task t_batch;
        p = '0;
        p.batch_ok = 1'b1;
        pulse(p);
        chk_bit("batch_pass", 1'b1, st.batch_pass);
        p = '0;
        p.batch_ng = 1'b1;
        pulse(p);
        chk_bit("batch_pass", 1'b0, st.batch_pass);
        chk_bit("batch_fail", 1'b1, st.batch_fail);
        bus(1'b1, fso_pkg::OFS_CLEAR, 32'h2);
        chk_bit("batch_fail", 1'b0, st.batch_fail);
        $display("test batch done");
    endtask : t_batch

    task t_job;
        bus(1'b1, fso_pkg::OFS_CTRL, 32'h0000_0303);
        @(posedge clk_sys);
        ev.op_channel <= 7'h2A;
        p = '0;
        p.job_start = 1'b1;
        pulse(p);
        chk_bit("active", 1'b1, st.sequence_active);
        chk_word("echo", 32'h2A, {25'h0, st.channel_echo});
        p = '0;
        p.step_end = 1'b1;
        pulse(p);
        chk_bit("step_done", 1'b1, st.step_done);
        p = '0;
        p.cycle_begin = 1'b1;
        pulse(p);
        p = '0;
        p.cycle_end = 1'b1;
        p.judged_ng = 1'b1;
        pulse(p);
        p = '0;
        p.job_end = 1'b1;
        pulse(p);
        chk_bit("seq_done", 1'b1, st.sequence_done);
        chk_bit("seq_fail", 1'b1, st.sequence_fail);
        chk_bit("seq_pass", 1'b0, st.sequence_pass);
        chk_bit("active", 1'b0, st.sequence_active);
        bus(1'b1, fso_pkg::OFS_CTRL, 32'h0000_0301);
        p = '0;
        p.job_start = 1'b1;
        pulse(p);
        chk_bit("seq_fail", 1'b0, st.sequence_fail);
        @(posedge clk_sys);
        reject <= 1'b1;
        @(posedge clk_sys);
        reject <= 1'b0;
        #1;
        chk_bit("seq_fail", 1'b1, st.sequence_fail);
        p = '0;
        p.job_end = 1'b1;
        pulse(p);
        chk_bit("seq_pass", 1'b1, st.sequence_pass);
        p = '0;
        p.job_start = 1'b1;
        pulse(p);
        p = '0;
        p.job_abort = 1'b1;
        pulse(p);
        chk_bit("aborted", 1'b1, st.sequence_aborted);
        chk_bit("active", 1'b0, st.sequence_active);
        bus(1'b1, fso_pkg::OFS_CTRL, 32'h0000_5500);
        tick(1);
        chk_word("echo", 32'h55, {25'h0, st.channel_echo});
        $display("test job done");
    endtask : t_job

    task t_lock;
        @(posedge clk_sys);
        lock <= 1'b1;
        tick(1);
        chk_bit("lock_echo", 1'b1, st.lock_echo);
        chk_bit("inhibit", 1'b0, st.tool_inhibited);
        @(posedge clk_sys);
        ev.tool_locked <= 1'b1;
        ev.count_complete <= 1'b1;
        tick(1);
        chk_bit("inhibit", 1'b1, st.tool_inhibited);
        tick(1);
        chk_bit("ready", 1'b0, st.ready);
        @(posedge clk_sys);
        lock <= 1'b0;
        tick(1);
        chk_bit("lock_echo", 1'b0, st.lock_echo);
        chk_bit("inhibit", 1'b0, st.tool_inhibited);
        @(posedge clk_sys);
        ev.tool_locked <= 1'b0;
        ev.count_complete <= 1'b0;
        $display("test lock done");
    endtask : t_lock

    task t_vid;
        int n;
        n = 0;
        @(posedge clk_sys);
        vehicle_id <= 32'h3C5A_9617;
        vid_go <= 1'b1;
        @(posedge clk_sys);
        vid_go <= 1'b0;
        do begin
            tick(1);
            n++;
        end while (st.vehicle_id_ack !== 1'b1 && n < 20);
        chk_bit("ack", 1'b1, st.vehicle_id_ack);
        bus(1'b0, fso_pkg::OFS_VID, 32'h0);
        chk_word("vid", 32'h3C5A_9617, rd);
        n = 0;
        while (vid_done !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        chk_bit("ack", 1'b0, st.vehicle_id_ack);
        p = '0;
        p.serial_err = 1'b1;
        pulse(p);
        chk_bit("serial_err", 1'b1, st.serial_err);
        bus(1'b1, fso_pkg::OFS_CLEAR, 32'h8);
        chk_bit("serial_err", 1'b0, st.serial_err);
        $display("test vid done");
    endtask : t_vid

    initial begin
        #200000;
        mismatches++;
        summarize();
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_cycle();
        t_batch();
        t_job();
        t_lock();
        t_vid();
        summarize();
    end
endmodule : tb_fso_status_outputs
